// File: rtl/hdlcif_event_flags.sv
/*
  HDLC event flag register with interrupt enable mask and request output.
  Assumes the microport front end presents each access as a level (acc.active)
  with stable address and data, and that FIFO levels come from logic on clk.
*/
// Summary of operation
// [R1] Reading the event register returns flags, then clears them and the request.
// [R2] Flags set on source transitions and stay set until read.
// [R3] Events during a read are held and posted afterwards unless already set.
// [R4] Software polls the status register to see if a condition persists.
// [R5] Request is the OR of each flag ANDed with its enable bit.
// [R6] Bit 7 sets when the receiver sees a go-ahead pattern.
// [R7] Bit 6 sets when an end-of-packet byte enters the receive FIFO.
// [R8] Bit 5 sets when a packet's closing flag is sent or it aborts.
// [R9] Bit 4 sets on last byte next, or reading an empty receive FIFO.
// [R10] Bit 3 sets on transmit level 5 to 4, or 15 to 14 shifted.
// [R11] Bit 2 sets on received abort after at least 26 bits, select low.
// [R12] Bit 2 sets on transmit underrun when the select is high.
// [R13] Bit 1 sets on receive level 14 to 15, or 4 to 5 shifted.
// [R14] Bit 0 sets when the receiver writes into a full FIFO.
// [R15] A receive overflow disables the receiver.
// [R16] The receiver re-enables on the next flag sequence.
// [R17] After reset all eight flags read zero.
// [R18] A masked flag still sets but raises no request.
// [R19] Pending bit sets with an enabled event and clears on flag read.
// [R20] Asynchronous sources are synchronised before edge detection.
`default_nettype none
module hdlcif_event_flags
  import hdlcif_pkg::*;
(
  input wire logic clk,                                 // Device clock
  input wire logic rst_n,                               // Synchronous reset, active low
  input wire hdlcif_acc_t acc,                          // Microport access in progress
  input wire logic intsel,                              // Bit 2 source: 1 underrun, 0 abort
  input wire logic fltx,                                // Transmit level shift
  input wire logic flrx,                                // Receive level shift
  input wire logic [HDLCIF_ASYNC_COUNT-1:0] async_evt,  // Asynchronous source levels
  input wire hdlcif_fifo_t fifo,                        // Same-clock FIFO and receiver state
  output logic [7:0] acc_rdata,                         // Read data for the access
  output logic [7:0] event_flags,                       // Current flag register
  output logic irq_n,                                   // Interrupt request, active low
  output logic irq_pending,                             // Status register pending bit
  output logic rx_enable                                // Receiver enable
);
  logic [HDLCIF_ASYNC_COUNT-1:0] as_rise;
  logic acc_prev_r;
  logic acc_start, acc_end, rd_fifo_empty;
  hdlcif_acc_state_t acc_state_r, acc_state_nxt;
  logic [4:0] tx_prev_r, rx_prev_r;
  logic abort_prev_r;
  logic [7:0] evt;
  logic [7:0] flags_r, flags_nxt, held_r, held_nxt;
  logic [7:0] enable_r, enable_nxt, rdata_r, rdata_nxt;
  logic irq_n_r, irq_n_nxt, pend_r, pend_nxt, rx_en_r, rx_en_nxt;

  function automatic logic crossed(input logic [4:0] prev, input logic [4:0] cur,
                                   input logic [4:0] from, input logic [4:0] to);
    crossed = (prev == from) && (cur == to);
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < HDLCIF_ASYNC_COUNT; gi++) begin : g_sync
      hdlcif_sync_edge u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(async_evt[gi]),
        .rise(as_rise[gi])
      );
    end
  endgenerate

  assign acc_start = acc.active & ~acc_prev_r;
  assign acc_end = ~acc.active & acc_prev_r;
  assign rd_fifo_empty = acc_start & ~acc.write & (acc.addr == HDLCIF_ADDR_RXTX_FIFO) &
                         (fifo.rx_level == HDLCIF_FIFO_EMPTY);

  // Event sources, one pulse per transition
  always_comb begin
    evt = 8'h00;
    evt[HDLCIF_BIT_GO_AHEAD] = as_rise[HDLCIF_AS_GO_AHEAD]; // see [R6]
    evt[HDLCIF_BIT_RX_PKT_END] = as_rise[HDLCIF_AS_RX_PKT_END]; // see [R7]
    evt[HDLCIF_BIT_TX_PKT_DONE] = as_rise[HDLCIF_AS_TX_PKT_DONE]; // see [R8]
    evt[HDLCIF_BIT_RX_LAST_NEXT] = as_rise[HDLCIF_AS_RX_LAST_NEXT] | rd_fifo_empty; // see [R9]
    evt[HDLCIF_BIT_TX_FIFO_LOW] = fltx ? // see [R10]
        crossed(tx_prev_r, fifo.tx_level, HDLCIF_TX_LOW_FROM_SHIFT, HDLCIF_TX_LOW_TO_SHIFT) :
        crossed(tx_prev_r, fifo.tx_level, HDLCIF_TX_LOW_FROM, HDLCIF_TX_LOW_TO);
    if (intsel) begin
      evt[HDLCIF_BIT_ABORT_UNDER] = as_rise[HDLCIF_AS_TX_UNDERRUN]; // see [R12]
    end else begin
      evt[HDLCIF_BIT_ABORT_UNDER] = fifo.abort_seen & ~abort_prev_r &
                                    (fifo.rx_bit_count >= HDLCIF_ABORT_MIN_BITS); // see [R11]
    end
    evt[HDLCIF_BIT_RX_NEAR_FULL] = flrx ? // see [R13]
        crossed(rx_prev_r, fifo.rx_level, HDLCIF_RX_FULL_FROM_SHIFT, HDLCIF_RX_FULL_TO_SHIFT) :
        crossed(rx_prev_r, fifo.rx_level, HDLCIF_RX_FULL_FROM, HDLCIF_RX_FULL_TO);
    evt[HDLCIF_BIT_RX_OVERFLOW] = fifo.rx_write_try & fifo.rx_full; // see [R14]
  end

  // Access tracking, flags, mask and request
  always_comb begin
    acc_state_nxt = acc_state_r;
    flags_nxt = flags_r | evt; // see [R2]
    held_nxt = held_r;
    enable_nxt = enable_r;
    rdata_nxt = rdata_r;
    case (acc_state_r)
      HDLCIF_RD_IDLE: begin
        if (acc_start) begin
          if (!acc.write && acc.addr == HDLCIF_ADDR_EVENT_FLAGS) begin
            acc_state_nxt = HDLCIF_RD_FLAGS;
          end else begin
            acc_state_nxt = HDLCIF_RD_OTHER;
          end
          if (acc.write && acc.addr == HDLCIF_ADDR_INT_ENABLE) begin
            enable_nxt = acc.wdata;
          end
          if (!acc.write) begin
            if (acc.addr == HDLCIF_ADDR_EVENT_FLAGS) begin
              rdata_nxt = flags_r | evt; // see [R1]
              flags_nxt = flags_r | evt;
            end else if (acc.addr == HDLCIF_ADDR_INT_ENABLE) begin
              rdata_nxt = enable_r;
            end else begin
              rdata_nxt = HDLCIF_RDATA_RESET;
            end
          end
        end
      end
      HDLCIF_RD_FLAGS: begin
        flags_nxt = flags_r;
        if (acc_end) begin
          flags_nxt = held_r | evt; // see [R1] [R3]
          held_nxt = 8'h00;
          acc_state_nxt = HDLCIF_RD_IDLE;
        end else begin
          held_nxt = held_r | (evt & ~flags_r); // see [R3]
        end
      end
      HDLCIF_RD_OTHER: begin
        if (acc_end) begin
          acc_state_nxt = HDLCIF_RD_IDLE;
        end
      end
      default: begin
        acc_state_nxt = HDLCIF_RD_IDLE;
      end
    endcase
    pend_nxt = |(flags_nxt & enable_nxt); // see [R5] [R18] [R19]
    irq_n_nxt = ~pend_nxt; // see [R5]
  end

  // Receiver shut-off on overflow, restart on flag
  always_comb begin
    rx_en_nxt = rx_en_r;
    if (evt[HDLCIF_BIT_RX_OVERFLOW]) begin
      rx_en_nxt = 1'b0; // see [R15]
    end else if (as_rise[HDLCIF_AS_FLAG_SEEN]) begin
      rx_en_nxt = 1'b1; // see [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_prev_r <= 1'b0;
      acc_state_r <= HDLCIF_RD_IDLE;
      tx_prev_r <= HDLCIF_FIFO_EMPTY;
      rx_prev_r <= HDLCIF_FIFO_EMPTY;
      abort_prev_r <= 1'b0;
      flags_r <= HDLCIF_FLAGS_RESET; // see [R17]
      held_r <= HDLCIF_FLAGS_RESET;
      enable_r <= HDLCIF_ENABLE_RESET;
      rdata_r <= HDLCIF_RDATA_RESET;
      irq_n_r <= 1'b1;
      pend_r <= 1'b0;
      rx_en_r <= HDLCIF_RX_ENABLE_RESET;
    end else begin
      acc_prev_r <= acc.active;
      acc_state_r <= acc_state_nxt;
      tx_prev_r <= fifo.tx_level;
      rx_prev_r <= fifo.rx_level;
      abort_prev_r <= fifo.abort_seen;
      flags_r <= flags_nxt;
      held_r <= held_nxt;
      enable_r <= enable_nxt;
      rdata_r <= rdata_nxt;
      irq_n_r <= irq_n_nxt;
      pend_r <= pend_nxt;
      rx_en_r <= rx_en_nxt;
    end
  end

  assign acc_rdata = rdata_r;
  assign event_flags = flags_r;
  assign irq_n = irq_n_r;
  assign irq_pending = pend_r;
  assign rx_enable = rx_en_r;

  property p_read_clears;
    @(posedge clk) disable iff (!rst_n)
      (acc_state_r == HDLCIF_RD_FLAGS && acc_end && held_r == 8'h00 && evt == 8'h00)
      |=> (flags_r == 8'h00) && irq_n_r && !pend_r;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag read did not clear"); // see [R1]

  property p_sticky;
    @(posedge clk) disable iff (!rst_n)
      (acc_state_r != HDLCIF_RD_FLAGS) |=> ((flags_r & $past(flags_r)) == $past(flags_r));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost outside a read"); // see [R2]

  property p_held_posted;
    @(posedge clk) disable iff (!rst_n)
      (acc_state_r == HDLCIF_RD_FLAGS && acc_end && held_r != 8'h00)
      |=> ((flags_r & $past(held_r)) == $past(held_r));
  endproperty
  a_held_posted: assert property (p_held_posted) else $error("event during read lost"); // see [R3]

  property p_read_frozen;
    @(posedge clk) disable iff (!rst_n)
      (acc_state_r == HDLCIF_RD_FLAGS && !acc_end) |=> (flags_r == $past(flags_r));
  endproperty
  a_read_frozen: assert property (p_read_frozen) else $error("flags moved during a read"); // see [R3]

  property p_irq_mask;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |-> (irq_n_r == ~|(flags_r & enable_r)) && (pend_r == ~irq_n_r);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request not flags and enable"); // see [R5] [R19]

  property p_masked_quiet;
    @(posedge clk) disable iff (!rst_n)
      ((flags_r & ~enable_r) != 8'h00 && (flags_r & enable_r) == 8'h00) |-> irq_n_r;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked flag raised request"); // see [R18]

  property p_go_ahead;
    @(posedge clk) disable iff (!rst_n)
      (as_rise[HDLCIF_AS_GO_AHEAD] && acc_state_r == HDLCIF_RD_IDLE) |=> flags_r[HDLCIF_BIT_GO_AHEAD];
  endproperty
  a_go_ahead: assert property (p_go_ahead) else $error("go-ahead flag not set"); // see [R6]

  property p_rx_pkt_end;
    @(posedge clk) disable iff (!rst_n)
      (as_rise[HDLCIF_AS_RX_PKT_END] && acc_state_r == HDLCIF_RD_IDLE) |=> flags_r[HDLCIF_BIT_RX_PKT_END];
  endproperty
  a_rx_pkt_end: assert property (p_rx_pkt_end) else $error("packet end flag not set"); // see [R7]

  property p_tx_done;
    @(posedge clk) disable iff (!rst_n)
      (as_rise[HDLCIF_AS_TX_PKT_DONE] && acc_state_r == HDLCIF_RD_IDLE) |=> flags_r[HDLCIF_BIT_TX_PKT_DONE];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("transmit done flag not set"); // see [R8]

  property p_tx_low;
    @(posedge clk) disable iff (!rst_n)
      (!fltx && fifo.tx_level == HDLCIF_TX_LOW_TO && $past(fifo.tx_level) == HDLCIF_TX_LOW_FROM &&
       acc_state_r == HDLCIF_RD_IDLE) |=> flags_r[HDLCIF_BIT_TX_FIFO_LOW];
  endproperty
  a_tx_low: assert property (p_tx_low) else $error("transmit low flag not set"); // see [R10]

  property p_short_abort;
    @(posedge clk) disable iff (!rst_n)
      (!intsel && fifo.rx_bit_count < HDLCIF_ABORT_MIN_BITS && !flags_r[HDLCIF_BIT_ABORT_UNDER] &&
       acc_state_r == HDLCIF_RD_IDLE) |=> !flags_r[HDLCIF_BIT_ABORT_UNDER];
  endproperty
  a_short_abort: assert property (p_short_abort) else $error("short abort set flag"); // see [R11]

  property p_underrun;
    @(posedge clk) disable iff (!rst_n)
      (intsel && as_rise[HDLCIF_AS_TX_UNDERRUN] && acc_state_r == HDLCIF_RD_IDLE) |=> flags_r[HDLCIF_BIT_ABORT_UNDER];
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun flag not set"); // see [R12]

  property p_rx_full;
    @(posedge clk) disable iff (!rst_n)
      (!flrx && fifo.rx_level == HDLCIF_RX_FULL_TO && $past(fifo.rx_level) == HDLCIF_RX_FULL_FROM &&
       acc_state_r == HDLCIF_RD_IDLE) |=> flags_r[HDLCIF_BIT_RX_NEAR_FULL];
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("receive nearly full flag not set"); // see [R13]

  property p_empty_read;
    @(posedge clk) disable iff (!rst_n)
      rd_fifo_empty |=> flags_r[HDLCIF_BIT_RX_LAST_NEXT];
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty FIFO read flag not set"); // see [R9]

  property p_overflow_off;
    @(posedge clk) disable iff (!rst_n)
      (fifo.rx_write_try && fifo.rx_full) |=> !rx_en_r ##0 (acc_state_r != HDLCIF_RD_IDLE ||
                                                            flags_r[HDLCIF_BIT_RX_OVERFLOW]);
  endproperty
  a_overflow_off: assert property (p_overflow_off) else $error("overflow did not stop receiver"); // see [R14] [R15]

  property p_flag_restart;
    @(posedge clk) disable iff (!rst_n)
      (as_rise[HDLCIF_AS_FLAG_SEEN] && !evt[HDLCIF_BIT_RX_OVERFLOW]) |=> rx_en_r;
  endproperty
  a_flag_restart: assert property (p_flag_restart) else $error("receiver not re-enabled"); // see [R16]

  property p_reset_zero;
    @(posedge clk) !rst_n |=> (flags_r == 8'h00) && irq_n_r;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset"); // see [R17]
endmodule
`default_nettype wire

// File: rtl/hdlcif_pkg.sv
/*
  Shared constants, field positions and carrier types for the HDLC event flag block.
  Assumes a single device clock and a synchronous active-low reset.
*/
`default_nettype none
package hdlcif_pkg;
  // Microport register offsets
  localparam logic [7:0] HDLCIF_ADDR_RXTX_FIFO = 8'h02;
  localparam logic [7:0] HDLCIF_ADDR_INT_ENABLE = 8'h06;
  localparam logic [7:0] HDLCIF_ADDR_EVENT_FLAGS = 8'h07;

  // Reset values
  localparam logic [7:0] HDLCIF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] HDLCIF_ENABLE_RESET = 8'h00;
  localparam logic [7:0] HDLCIF_RDATA_RESET = 8'h00;
  localparam logic HDLCIF_RX_ENABLE_RESET = 1'b1;

  // Event flag bit positions
  localparam int HDLCIF_BIT_GO_AHEAD = 7;
  localparam int HDLCIF_BIT_RX_PKT_END = 6;
  localparam int HDLCIF_BIT_TX_PKT_DONE = 5;
  localparam int HDLCIF_BIT_RX_LAST_NEXT = 4;
  localparam int HDLCIF_BIT_TX_FIFO_LOW = 3;
  localparam int HDLCIF_BIT_ABORT_UNDER = 2;
  localparam int HDLCIF_BIT_RX_NEAR_FULL = 1;
  localparam int HDLCIF_BIT_RX_OVERFLOW = 0;

  // Index of each asynchronous source in the async event vector
  localparam int HDLCIF_ASYNC_COUNT = 6;
  localparam int HDLCIF_AS_GO_AHEAD = 0;
  localparam int HDLCIF_AS_RX_PKT_END = 1;
  localparam int HDLCIF_AS_TX_PKT_DONE = 2;
  localparam int HDLCIF_AS_RX_LAST_NEXT = 3;
  localparam int HDLCIF_AS_TX_UNDERRUN = 4;
  localparam int HDLCIF_AS_FLAG_SEEN = 5;

  // FIFO level thresholds
  localparam logic [4:0] HDLCIF_TX_LOW_FROM = 5'h05;
  localparam logic [4:0] HDLCIF_TX_LOW_TO = 5'h04;
  localparam logic [4:0] HDLCIF_TX_LOW_FROM_SHIFT = 5'h0F;
  localparam logic [4:0] HDLCIF_TX_LOW_TO_SHIFT = 5'h0E;
  localparam logic [4:0] HDLCIF_RX_FULL_FROM = 5'h0E;
  localparam logic [4:0] HDLCIF_RX_FULL_TO = 5'h0F;
  localparam logic [4:0] HDLCIF_RX_FULL_FROM_SHIFT = 5'h04;
  localparam logic [4:0] HDLCIF_RX_FULL_TO_SHIFT = 5'h05;
  localparam logic [4:0] HDLCIF_FIFO_EMPTY = 5'h00;

  // Least received packet bits before an abort counts
  localparam logic [5:0] HDLCIF_ABORT_MIN_BITS = 6'h1A;

  typedef struct packed {
    logic active;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hdlcif_acc_t;

  typedef struct packed {
    logic [4:0] tx_level;
    logic [4:0] rx_level;
    logic rx_write_try;
    logic rx_full;
    logic abort_seen;
    logic [5:0] rx_bit_count;
  } hdlcif_fifo_t;

  typedef enum logic [1:0] {
    HDLCIF_RD_IDLE,
    HDLCIF_RD_FLAGS,
    HDLCIF_RD_OTHER
  } hdlcif_acc_state_t;
endpackage
`default_nettype wire

// File: rtl/hdlcif_sync_edge.sv
/*
  Three-stage synchroniser with agreement filter and rising-edge pulse.
  Assumes din is asynchronous to clk; the output pulse lasts one clock.
*/
`default_nettype none
module hdlcif_sync_edge
  import hdlcif_pkg::*;
(
  input wire logic clk,   // Device clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic din,   // Asynchronous level
  output logic rise       // One-cycle pulse per accepted rising edge
);
  logic s1_r, s2_r, s3_r, level_r, rise_r;
  logic level_nxt, rise_nxt;

  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin // see [R20]
      level_nxt = s3_r;
    end
    rise_nxt = level_nxt & ~level_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise = rise_r;

  property p_single_pulse;
    @(posedge clk) disable iff (!rst_n) rise_r |=> !rise_r;
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("edge pulse longer than one cycle"); // see [R20]
endmodule
`default_nettype wire

// File: sim/hdlcif_host_model.sv
/*
  Host microprocessor model for the microport access level of the event flag block.
  Assumes the bench calls its access task from one process at a time.
*/
`default_nettype none
module hdlcif_host_model
  import hdlcif_pkg::*;
(
  input wire logic clk,             // Device clock
  input wire logic [7:0] acc_rdata, // Read answer from the block
  output hdlcif_acc_t acc           // Access towards the block
);
  timeunit 1ns;
  timeprecision 1ns;

  initial acc = '{1'b0, 1'b0, 8'h5A, 8'hA5};

  // Holds the access for hold cycles, takes the answer, then idles two cycles
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, input int hold,
                        output logic [7:0] rdata);
    @(negedge clk);
    acc = '{1'b1, wr, addr, wdata};
    repeat (hold) @(negedge clk);
    rdata = acc_rdata;
    // Idle address and data show the inverse, never the last value; the write line keeps it
    acc = '{1'b0, wr, ~addr, ~wdata};
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: sim/hdlcif_event_flags_test.sv
/*
  Self-checking bench for the event flag block, driving inputs on the falling edge.
  Assumes the host model for register accesses and plain levels for every event source.
*/
`default_nettype none
module hdlcif_event_flags_test
  import hdlcif_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic intsel = 1'b0;
  logic fltx = 1'b0;
  logic flrx = 1'b0;
  logic [5:0] async_evt = 6'h00;
  hdlcif_fifo_t fifo = '{5'h0A, 5'h08, 1'b0, 1'b0, 1'b0, 6'h00};
  hdlcif_acc_t acc;
  logic [7:0] acc_rdata, event_flags, rd;
  logic [7:0] en = 8'h00;
  logic irq_n, irq_pending, rx_enable;
  int err_total = 0;
  int tests_run = 0;

  always #50 clk = ~clk;

  hdlcif_host_model host (.clk(clk), .acc_rdata(acc_rdata), .acc(acc));

  hdlcif_event_flags dut (.clk(clk), .rst_n(rst_n), .acc(acc), .intsel(intsel), .fltx(fltx), .flrx(flrx),
    .async_evt(async_evt), .fifo(fifo), .acc_rdata(acc_rdata), .event_flags(event_flags), .irq_n(irq_n),
    .irq_pending(irq_pending), .rx_enable(rx_enable));

  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
    host.access(1'b0, a, 8'h00, 2, d);
  endtask

  task automatic wrreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.access(1'b1, a, d, 2, unused);
  endtask

  task automatic pulse(input int i);
    async_evt[i] = 1'b1;
    repeat (4) @(negedge clk);
    async_evt[i] = 1'b0;
  endtask

  // Flags and request after the event, then the clearing read
  task automatic flag_check(input logic [7:0] exp);
    logic [7:0] d;
    repeat (8) @(negedge clk);
    chk(event_flags, exp);
    chk({7'h00, irq_n}, {7'h00, ~|(exp & en)});
    chk({7'h00, irq_pending}, {7'h00, |(exp & en)});
    rdreg(HDLCIF_ADDR_EVENT_FLAGS, d);
    chk(d, exp);
    chk(event_flags, 8'h00);
    chk({6'h00, irq_pending, irq_n}, 8'h01);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(event_flags, HDLCIF_FLAGS_RESET);
    chk({5'h00, irq_pending, irq_n, rx_enable}, 8'h03);
    rdreg(HDLCIF_ADDR_EVENT_FLAGS, rd);
    chk(rd, 8'h00);
    rdreg(HDLCIF_ADDR_INT_ENABLE, rd);
    chk(rd, HDLCIF_ENABLE_RESET);
    wrreg(HDLCIF_ADDR_INT_ENABLE, 8'hFF);
    en = 8'hFF;
    rdreg(HDLCIF_ADDR_INT_ENABLE, rd);
    chk(rd, 8'hFF);
    rdreg(8'h10, rd);
    chk(rd, 8'h00);
    wrreg(HDLCIF_ADDR_EVENT_FLAGS, 8'h55);
    chk(event_flags, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      flag_check(8'h80 >> i);
    end
    fifo.tx_level = 5'h06;
    @(negedge clk) fifo.tx_level = 5'h04;
    flag_check(8'h00);
    fifo.tx_level = 5'h05;
    @(negedge clk) fifo.tx_level = 5'h04;
    flag_check(8'h08);
    fltx = 1'b1;
    fifo.tx_level = 5'h0F;
    @(negedge clk) fifo.tx_level = 5'h0E;
    flag_check(8'h08);
    fifo.tx_level = 5'h05;
    @(negedge clk) fifo.tx_level = 5'h04;
    flag_check(8'h00);
    fltx = 1'b0;
    fifo.tx_level = 5'h0A;
    fifo.rx_level = 5'h0E;
    @(negedge clk) fifo.rx_level = 5'h0F;
    flag_check(8'h02);
    flrx = 1'b1;
    fifo.rx_level = 5'h04;
    @(negedge clk) fifo.rx_level = 5'h05;
    flag_check(8'h02);
    fifo.rx_level = 5'h0E;
    @(negedge clk) fifo.rx_level = 5'h0F;
    flag_check(8'h00);
    flrx = 1'b0;
    fifo.rx_level = 5'h08;
    fifo.rx_bit_count = 6'h19;
    fifo.abort_seen = 1'b1;
    @(negedge clk) fifo.abort_seen = 1'b0;
    flag_check(8'h00);
    fifo.rx_bit_count = 6'h1A;
    fifo.abort_seen = 1'b1;
    @(negedge clk) fifo.abort_seen = 1'b0;
    flag_check(8'h04);
    intsel = 1'b1;
    pulse(HDLCIF_AS_TX_UNDERRUN);
    flag_check(8'h04);
    intsel = 1'b0;
    fifo.rx_write_try = 1'b1;
    fifo.rx_full = 1'b1;
    @(negedge clk) fifo.rx_write_try = 1'b0;
    fifo.rx_full = 1'b0;
    chk({7'h00, rx_enable}, 8'h00);
    flag_check(8'h01);
    chk({7'h00, rx_enable}, 8'h00);
    pulse(HDLCIF_AS_FLAG_SEEN);
    repeat (8) @(negedge clk);
    chk({7'h00, rx_enable}, 8'h01);
    fifo.rx_level = 5'h00;
    rdreg(HDLCIF_ADDR_RXTX_FIFO, rd);
    flag_check(8'h10);
    fifo.rx_level = 5'h08;
    wrreg(HDLCIF_ADDR_INT_ENABLE, 8'h00);
    en = 8'h00;
    pulse(HDLCIF_AS_GO_AHEAD);
    flag_check(8'h80);
    wrreg(HDLCIF_ADDR_INT_ENABLE, 8'hFF);
    en = 8'hFF;
    // Flag 3 set first, so the first mid-read crossing is dropped, the second held
    fifo.tx_level = 5'h05;
    @(negedge clk) fifo.tx_level = 5'h04;
    repeat (2) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      fork
        host.access(1'b0, HDLCIF_ADDR_EVENT_FLAGS, 8'h00, 6, rd);
        begin
          repeat (3) @(negedge clk);
          fifo.tx_level = 5'h05;
          @(negedge clk) fifo.tx_level = 5'h04;
        end
      join
      chk(rd, (k == 0) ? 8'h08 : 8'h00);
      chk(event_flags, (k == 0) ? 8'h00 : 8'h08);
    end
    flag_check(8'h08);
    wrap_up;
  end

  initial begin
    #500000;
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire
